// [async_timer_compare_unit.sv]
// 8-bit timer with one compare channel, register access over axi4-lite
// assumes one core clock and an external crystal pin for async timing
// Contract
// - compare value is double buffered in pwm modes, direct otherwise.
// - the buffered compare value moves to the active one only at top.
// - cpu writes reach the buffer in pwm modes, the active value otherwise.
// - force compare in non-pwm modes drives the pin, without flag or reload.
// - a counter write suppresses any compare match on the next timer tick.
// - async select chooses core clock at zero, crystal pin at one.
// - an async counter write sets its pending flag until loaded.
// - an async compare write sets its pending flag until loaded.
// - an async control write sets its pending flag until loaded.
// - counter reads are live; compare and control read their temp copy.
// - compare interrupt needs its enable, global enable and its flag.
// - overflow interrupt needs its enable, global enable and its flag.
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module async_timer_compare_unit
  import timer_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              timer_osc_input,
  output logic                   compare_output_pin,
  output logic                   compare_output_en,
  output logic                   irq
);
  typedef struct packed {
    logic              aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_got;
    logic [7:0]        w_data;
    logic              w_lane0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [7:0]        rdata;
    logic [1:0]        rresp;
    logic [7:0]        timer_control_a;
    logic [7:0]        control_temp;
    logic [7:0]        counter_value;
    logic [7:0]        counter_temp;
    logic              count_down;
    logic [7:0]        compare_active;
    logic [7:0]        compare_buf;
    logic [7:0]        compare_temp;
    logic              async_clock_select;
    logic [2:0]        update_pending;
    logic              force_pending;
    logic              match_block;
    logic [1:0]        timer_flag_register;
    logic [1:0]        timer_irq_mask;
    logic              global_irq_enable;
    logic              pin;
  } unit_state_t;

  unit_state_t s;
  unit_state_t next_s;
  logic        tick;
  logic        wr_fire;
  logic        loaded;
  logic        match;
  logic        at_top;
  logic [1:0]  flag_set;
  logic [1:0]  flag_clr;
  logic [1:0]  com;
  logic [1:0]  mode;
  logic [7:0]  wd;

  function automatic logic is_pwm(input logic [1:0] m);
    is_pwm = (m == MODE_PHASE) || (m == MODE_FAST);
  endfunction

  function automatic logic act(input logic p, input logic [1:0] c);
    if (c == COM_TOGGLE) begin
      act = ~p;
    end else if (c == COM_CLEAR) begin
      act = 1'b0;
    end else if (c == COM_SET) begin
      act = 1'b1;
    end else begin
      act = p;
    end
  endfunction

  timer_tick_source u_tick (
    .core_clk           (core_clk),
    .rst                (rst),
    .timer_osc_input    (timer_osc_input),
    .async_clock_select (s.async_clock_select),
    .clock_select       (s.timer_control_a[CTL_CS_LSB +: 3]),
    .tick               (tick)
  );

  assign s_axi_awready      = ~s.aw_got & ~s.bvalid;
  assign s_axi_wready       = ~s.w_got & ~s.bvalid;
  assign s_axi_bvalid       = s.bvalid;
  assign s_axi_bresp        = s.bresp;
  assign s_axi_arready      = ~s.rvalid;
  assign s_axi_rvalid       = s.rvalid;
  assign s_axi_rresp        = s.rresp;
  assign s_axi_rdata        = {24'h000000, s.rdata};
  assign compare_output_pin = s.pin;
  assign compare_output_en  = s.timer_control_a[CTL_COM_LSB +: 2] != COM_OFF;
  assign irq = s.global_irq_enable &
               (|(s.timer_flag_register & s.timer_irq_mask));

  always_comb begin
    next_s   = s;
    flag_set = 2'h0;
    flag_clr = 2'h0;
    loaded   = 1'b0;
    match    = 1'b0;
    at_top   = 1'b0;
    wr_fire  = 1'b0;
    wd       = s.w_data;
    mode     = s.timer_control_a[CTL_MODE_LSB +: 2];
    com      = s.timer_control_a[CTL_COM_LSB +: 2];

    // timer tick: async loads first; no count on a tick that loads the counter
    if (tick) begin
      if (s.update_pending[PEND_COUNTER]) begin
        next_s.counter_value                 = s.counter_temp;
        next_s.update_pending[PEND_COUNTER] = 1'b0;
        next_s.match_block                   = 1'b1;
        loaded                               = 1'b1;
      end
      if (s.update_pending[PEND_COMPARE]) begin
        next_s.update_pending[PEND_COMPARE] = 1'b0;
        if (is_pwm(mode)) begin
          next_s.compare_buf = s.compare_temp;
        end else begin
          next_s.compare_active = s.compare_temp;
          next_s.compare_buf    = s.compare_temp;
        end
      end
      if (s.update_pending[PEND_CONTROL]) begin
        next_s.timer_control_a               = s.control_temp;
        next_s.update_pending[PEND_CONTROL] = 1'b0;
        next_s.force_pending                 = 1'b0;
        if (s.force_pending) begin
          next_s.pin = act(s.pin, s.control_temp[CTL_COM_LSB +: 2]);
        end
      end
      if (!loaded) begin
        match              = (s.counter_value == s.compare_active) &&
                             !s.match_block;
        next_s.match_block = 1'b0;
        at_top             = s.counter_value == CNT_MAX;
        if (match) begin
          flag_set[FLAG_COMPARE] = 1'b1;
        end
        if (mode == MODE_PHASE) begin
          if (!s.count_down) begin
            if (at_top) begin
              next_s.count_down    = 1'b1;
              next_s.counter_value = CNT_MAX - CNT_ONE;
            end else begin
              next_s.counter_value = s.counter_value + CNT_ONE;
            end
          end else if (s.counter_value == CNT_BOTTOM) begin
            next_s.count_down       = 1'b0;
            next_s.counter_value    = CNT_ONE;
            flag_set[FLAG_OVERFLOW] = 1'b1;
          end else begin
            next_s.counter_value = s.counter_value - CNT_ONE;
          end
          if (match) begin
            next_s.pin = (com == COM_CLEAR) ? s.count_down :
                         (com == COM_SET) ? ~s.count_down : s.pin;
          end
        end else begin
          if (mode == MODE_CTC && match) begin
            next_s.counter_value = CNT_BOTTOM;
          end else begin
            next_s.counter_value = s.counter_value + CNT_ONE;
          end
          next_s.count_down = 1'b0;
          if (at_top) begin
            flag_set[FLAG_OVERFLOW] = 1'b1;
          end
          if (mode == MODE_FAST) begin
            if (match && com != COM_TOGGLE) begin
              next_s.pin = act(s.pin, com);
            end else if (at_top && com == COM_CLEAR) begin
              next_s.pin = 1'b1;
            end else if (at_top && com == COM_SET) begin
              next_s.pin = 1'b0;
            end
          end else if (match) begin
            next_s.pin = act(s.pin, com);
          end
        end
        if (is_pwm(mode) && at_top) begin
          next_s.compare_active = s.compare_buf;
        end
      end
    end

    // bus write channel
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_got  = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_got   = 1'b1;
      next_s.w_data  = s_axi_wdata[7:0];
      next_s.w_lane0 = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = RESP_OKAY;
      wr_fire       = s.w_lane0;
      if (s.aw_addr == OFS_CONTROL) begin
        next_s.control_temp = wd & CTL_STORE_MSK;
        if (wr_fire && s.async_clock_select) begin
          next_s.update_pending[PEND_CONTROL] = 1'b1;
          next_s.force_pending = wd[CTL_FORCE] &&
                                 !is_pwm(wd[CTL_MODE_LSB +: 2]);
        end else if (wr_fire) begin
          next_s.timer_control_a = wd & CTL_STORE_MSK;
          if (wd[CTL_FORCE] && !is_pwm(wd[CTL_MODE_LSB +: 2])) begin
            next_s.pin = act(next_s.pin, wd[CTL_COM_LSB +: 2]);
          end
        end else begin
          next_s.control_temp = s.control_temp;
        end
      end else if (s.aw_addr == OFS_COUNTER) begin
        if (wr_fire && s.async_clock_select) begin
          next_s.counter_temp                  = wd;
          next_s.update_pending[PEND_COUNTER] = 1'b1;
        end else if (wr_fire) begin
          next_s.counter_value = wd;
          next_s.match_block   = 1'b1;
        end
      end else if (s.aw_addr == OFS_COMPARE) begin
        if (wr_fire) begin
          next_s.compare_temp = wd;
        end
        if (wr_fire && s.async_clock_select) begin
          next_s.update_pending[PEND_COMPARE] = 1'b1;
        end else if (wr_fire && is_pwm(mode)) begin
          next_s.compare_buf = wd;
        end else if (wr_fire) begin
          next_s.compare_active = wd;
          next_s.compare_buf    = wd;
        end
      end else if (s.aw_addr == OFS_ASYNC) begin
        if (wr_fire) begin
          next_s.async_clock_select = wd[AS_SEL_BIT];
          if (wd[AS_SEL_BIT] != s.async_clock_select) begin
            next_s.update_pending = 3'h0;
            next_s.force_pending  = 1'b0;
          end
        end
      end else if (s.aw_addr == OFS_FLAGS) begin
        if (wr_fire) begin
          flag_clr = wd[1:0];
        end
      end else if (s.aw_addr == OFS_MASK) begin
        if (wr_fire) begin
          next_s.timer_irq_mask = wd[1:0];
        end
      end else if (s.aw_addr == OFS_GLOBAL) begin
        if (wr_fire) begin
          next_s.global_irq_enable = wd[GIE_BIT];
        end
      end else begin
        next_s.bresp = RESP_SLVERR;
      end
    end
    // a new flag event wins over a clear
    next_s.timer_flag_register = (s.timer_flag_register & ~flag_clr) |
                                 flag_set;

    // bus read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      next_s.rdata  = RST_BYTE;
      if (s_axi_araddr == OFS_CONTROL) begin
        next_s.rdata = s.control_temp;
      end else if (s_axi_araddr == OFS_COUNTER) begin
        next_s.rdata = s.counter_value;
      end else if (s_axi_araddr == OFS_COMPARE) begin
        next_s.rdata = s.compare_temp;
      end else if (s_axi_araddr == OFS_ASYNC) begin
        next_s.rdata = {4'h0, s.async_clock_select, s.update_pending};
      end else if (s_axi_araddr == OFS_FLAGS) begin
        next_s.rdata = {6'h00, s.timer_flag_register};
      end else if (s_axi_araddr == OFS_MASK) begin
        next_s.rdata = {6'h00, s.timer_irq_mask};
      end else if (s_axi_araddr == OFS_GLOBAL) begin
        next_s.rdata = {7'h00, s.global_irq_enable};
      end else begin
        next_s.rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// [async_timer_compare_unit_test.sv]
// register-level bench for the asynchronous timer block
// assumes timer_pkg and the design files are compiled first
`timescale 1ns/100ps
module async_timer_compare_unit_test
  import timer_pkg::*;
;
  logic        core_clk      = 1'b0;
  logic        rst           = 1'b1;
  logic [4:0]  s_axi_awaddr  = 5'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic [3:0]  s_axi_wstrb   = 4'hF;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready  = 1'b0;
  logic [4:0]  s_axi_araddr  = 5'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready  = 1'b0;
  logic        timer_osc_input = 1'b0;
  logic        compare_output_pin;
  logic        compare_output_en;
  logic        irq;
  logic [31:0] rdat;
  logic [1:0]  rrsp;
  logic [1:0]  brsp;
  int          fails         = 0;
  int          n_checks      = 0;
  logic [1:0]  coms [4]      = '{COM_SET, COM_CLEAR, COM_TOGGLE, COM_TOGGLE};
  logic [3:0]  pin_seq       = 4'h5;

  async_timer_compare_unit uut (
    .core_clk(core_clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .timer_osc_input(timer_osc_input),
    .compare_output_pin(compare_output_pin),
    .compare_output_en(compare_output_en), .irq(irq)
  );

  always #5 core_clk = ~core_clk;

  function automatic logic [31:0] ctl(input logic [1:0] m,
                                      input logic [1:0] c,
                                      input logic [2:0] s);
    ctl = {24'h0, 1'b0, s, c, m};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // output levels are looked at mid-cycle, after updates land
  task automatic chk_irq(input logic e);
    repeat (2) @(negedge core_clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  task automatic chk_pin(input logic e);
    repeat (2) @(negedge core_clk);
    chk({31'h0, compare_output_pin}, {31'h0, e});
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready ||
               s_axi_wvalid && !s_axi_wready);
    do @(posedge core_clk); while (!s_axi_bvalid);
    brsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a);
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rc(input logic [4:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask

  task automatic close_out;
    if (fails == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    close_out;
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 0; a <= 24; a += 4) rc(a[4:0], 32'h0);
    rc(5'h1C, 32'h0);
    chk({30'h0, rrsp}, {30'h0, RESP_SLVERR});
    wr(5'h1C, 32'hFF);
    chk({30'h0, brsp}, {30'h0, RESP_SLVERR});
    // compare match, direct compare access, interrupt gating
    wr(OFS_MASK, 32'h2);
    wr(OFS_GLOBAL, 32'h1);
    wr(OFS_COMPARE, 32'h20);
    wr(OFS_COUNTER, 32'h10);
    wr(OFS_CONTROL, ctl(MODE_NORMAL, COM_OFF, CS_DIV1));
    repeat (30) @(posedge core_clk);
    rc(OFS_FLAGS, 32'h2);
    chk_irq(1'b1);
    wr(OFS_GLOBAL, 32'h0);
    chk_irq(1'b0);
    wr(OFS_GLOBAL, 32'h1);
    wr(OFS_MASK, 32'h0);
    chk_irq(1'b0);
    wr(OFS_MASK, 32'h2);
    wr(OFS_FLAGS, 32'h2);
    chk_irq(1'b0);
    // overflow at the wrap
    wr(OFS_CONTROL, ctl(MODE_NORMAL, COM_OFF, CS_STOP));
    wr(OFS_MASK, 32'h1);
    wr(OFS_COMPARE, 32'h80);
    wr(OFS_COUNTER, 32'hF0);
    wr(OFS_CONTROL, ctl(MODE_NORMAL, COM_OFF, CS_DIV1));
    repeat (30) @(posedge core_clk);
    rc(OFS_FLAGS, 32'h1);
    chk_irq(1'b1);
    wr(OFS_FLAGS, 32'h1);
    chk_irq(1'b0);
    // counter write equal to compare while stopped
    wr(OFS_CONTROL, ctl(MODE_NORMAL, COM_OFF, CS_STOP));
    wr(OFS_COMPARE, 32'h40);
    wr(OFS_COUNTER, 32'h40);
    wr(OFS_CONTROL, ctl(MODE_NORMAL, COM_OFF, CS_DIV1));
    repeat (5) @(posedge core_clk);
    rc(OFS_FLAGS, 32'h0);
    // forced compare in the set, clear and toggle output actions
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CONTROL, 32'h80 | ctl(MODE_NORMAL, coms[i], CS_STOP));
      chk_pin(pin_seq[i]);
    end
    rc(OFS_FLAGS, 32'h0);
    wr(OFS_CONTROL, 32'h80 | ctl(MODE_FAST, COM_SET, CS_STOP));
    chk_pin(1'b0);
    wr(OFS_CONTROL, ctl(MODE_NORMAL, COM_OFF, CS_STOP));
    chk({31'h0, compare_output_en}, 32'h0);
    // buffered compare in pwm, loaded at top only
    wr(OFS_COMPARE, 32'h04);
    wr(OFS_FLAGS, 32'h3);
    wr(OFS_CONTROL, ctl(MODE_FAST, COM_OFF, CS_STOP));
    wr(OFS_COMPARE, 32'h10);
    wr(OFS_COUNTER, 32'h08);
    wr(OFS_CONTROL, ctl(MODE_FAST, COM_OFF, CS_DIV1));
    repeat (12) @(posedge core_clk);
    rc(OFS_FLAGS, 32'h0);
    rc(OFS_COMPARE, 32'h10);
    repeat (270) @(posedge core_clk);
    rc(OFS_FLAGS, 32'h3);
    wr(OFS_FLAGS, 32'h3);
    wr(OFS_COUNTER, 32'h0C);
    repeat (8) @(posedge core_clk);
    rc(OFS_FLAGS, 32'h2);
    // clear on compare keeps the counter short of the wrap
    wr(OFS_CONTROL, ctl(MODE_CTC, COM_TOGGLE, CS_STOP));
    wr(OFS_COMPARE, 32'h20);
    wr(OFS_COUNTER, 32'h18);
    wr(OFS_FLAGS, 32'h3);
    wr(OFS_CONTROL, ctl(MODE_CTC, COM_TOGGLE, CS_DIV1));
    chk({31'h0, compare_output_en}, 32'h1);
    repeat (300) @(posedge core_clk);
    rc(OFS_FLAGS, 32'h2);
    // phase correct: no overflow at the top
    wr(OFS_CONTROL, ctl(MODE_PHASE, COM_OFF, CS_DIV1));
    wr(OFS_COUNTER, 32'hF8);
    wr(OFS_FLAGS, 32'h3);
    repeat (20) @(posedge core_clk);
    rc(OFS_FLAGS, 32'h0);
    // crystal clocking and update pending flags
    wr(OFS_CONTROL, ctl(MODE_NORMAL, COM_OFF, CS_DIV1));
    wr(OFS_FLAGS, 32'h3);
    wr(OFS_ASYNC, 32'h8);
    rc(OFS_ASYNC, 32'h8);
    wr(OFS_COUNTER, 32'h33);
    wr(OFS_COMPARE, 32'h44);
    wr(OFS_CONTROL, ctl(MODE_NORMAL, COM_OFF, CS_DIV1));
    rc(OFS_ASYNC, 32'hF);
    rc(OFS_COMPARE, 32'h44);
    repeat (8) begin
      repeat (5) @(posedge core_clk);
      timer_osc_input <= ~timer_osc_input;
    end
    repeat (10) @(posedge core_clk);
    rc(OFS_ASYNC, 32'h8);
    rc(OFS_COUNTER, 32'h36);
    rc(OFS_CONTROL, ctl(MODE_NORMAL, COM_OFF, CS_DIV1));
    close_out;
  end
endmodule

bind async_timer_compare_unit async_timer_monitor mon (
  .core_clk(core_clk), .rst(rst), .irq(irq),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .compare_output_pin(compare_output_pin)
);

// [async_timer_monitor.sv]
// checker for the timer block's bus handshakes and outputs
// assumes a bind into async_timer_compare_unit, one clock domain
`timescale 1ns/100ps
module async_timer_monitor
  import timer_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [4:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        compare_output_pin,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");

  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");

  property p_arblock;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_arblock: assert property (p_arblock) else $error("read taken early");

  property p_wblock;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wblock: assert property (p_wblock) else $error("write taken early");

  property p_wlat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_wlat: assert property (p_wlat) else $error("write answer late");

  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");

  property p_rhigh;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_rhigh: assert property (p_rhigh) else $error("read upper bits set");

  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > OFS_GLOBAL
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read ok");

  property p_reset;
    $fell(rst) |-> !irq && !s_axi_bvalid && !s_axi_rvalid
      && !compare_output_pin;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not idle");
endmodule

// [timer_pkg.sv]
// constants for the asynchronous timer with one compare channel
// assumes a single core clock; register map is 32-bit words on axi4-lite
package timer_pkg;
  localparam int          ADDR_W        = 5;
  localparam int          DATA_W        = 32;
  // register byte offsets
  localparam logic [4:0]  OFS_CONTROL   = 5'h00;
  localparam logic [4:0]  OFS_COUNTER   = 5'h04;
  localparam logic [4:0]  OFS_COMPARE   = 5'h08;
  localparam logic [4:0]  OFS_ASYNC     = 5'h0C;
  localparam logic [4:0]  OFS_FLAGS     = 5'h10;
  localparam logic [4:0]  OFS_MASK      = 5'h14;
  localparam logic [4:0]  OFS_GLOBAL    = 5'h18;
  // control fields
  localparam int          CTL_MODE_LSB  = 0;
  localparam int          CTL_COM_LSB   = 2;
  localparam int          CTL_CS_LSB    = 4;
  localparam int          CTL_FORCE     = 7;
  localparam logic [7:0]  CTL_STORE_MSK = 8'h7F;
  // async status fields
  localparam int          AS_SEL_BIT    = 3;
  localparam int          PEND_COUNTER  = 2;
  localparam int          PEND_COMPARE  = 1;
  localparam int          PEND_CONTROL  = 0;
  // flag and mask fields
  localparam int          FLAG_COMPARE  = 1;
  localparam int          FLAG_OVERFLOW = 0;
  localparam int          GIE_BIT       = 0;
  // reset values
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  // counter limits
  localparam logic [7:0]  CNT_MAX       = 8'hFF;
  localparam logic [7:0]  CNT_BOTTOM    = 8'h00;
  localparam logic [7:0]  CNT_ONE       = 8'h01;
  // waveform modes
  localparam logic [1:0]  MODE_NORMAL   = 2'h0;
  localparam logic [1:0]  MODE_PHASE    = 2'h1;
  localparam logic [1:0]  MODE_CTC      = 2'h2;
  localparam logic [1:0]  MODE_FAST     = 2'h3;
  // compare output actions
  localparam logic [1:0]  COM_OFF       = 2'h0;
  localparam logic [1:0]  COM_TOGGLE    = 2'h1;
  localparam logic [1:0]  COM_CLEAR     = 2'h2;
  localparam logic [1:0]  COM_SET       = 2'h3;
  // clock select codes and prescaler
  localparam logic [2:0]  CS_STOP       = 3'h0;
  localparam logic [2:0]  CS_DIV1       = 3'h1;
  localparam logic [2:0]  CS_DIV8       = 3'h2;
  localparam logic [2:0]  CS_DIV32      = 3'h3;
  localparam logic [2:0]  CS_DIV64      = 3'h4;
  localparam logic [2:0]  CS_DIV128     = 3'h5;
  localparam logic [2:0]  CS_DIV256     = 3'h6;
  localparam int          PRE_W         = 10;
  localparam logic [9:0]  PRE_M8        = 10'h007;
  localparam logic [9:0]  PRE_M32       = 10'h01F;
  localparam logic [9:0]  PRE_M64       = 10'h03F;
  localparam logic [9:0]  PRE_M128      = 10'h07F;
  localparam logic [9:0]  PRE_M256      = 10'h0FF;
  localparam logic [9:0]  PRE_M1024     = 10'h3FF;
  localparam logic [9:0]  PRE_ZERO      = 10'h000;
  // axi responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// [timer_tick_source.sv]
// timer clock source: one-cycle tick enable from core clock or crystal
// assumes timer_osc_input is an unsynchronised pin, far slower than core_clk
`timescale 1ns/100ps
module timer_tick_source
  import timer_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       timer_osc_input,
  input  wire logic       async_clock_select,
  input  wire logic [2:0] clock_select,
  output logic            tick
);
  typedef struct packed {
    logic             osc_meta;
    logic             osc_sync;
    logic             osc_prev;
    logic [PRE_W-1:0] pre;
  } src_state_t;

  src_state_t s;
  src_state_t next_s;
  logic       base;

  function automatic logic [PRE_W-1:0] pre_mask(input logic [2:0] cs);
    if (cs == CS_DIV8) begin
      pre_mask = PRE_M8;
    end else if (cs == CS_DIV32) begin
      pre_mask = PRE_M32;
    end else if (cs == CS_DIV64) begin
      pre_mask = PRE_M64;
    end else if (cs == CS_DIV128) begin
      pre_mask = PRE_M128;
    end else if (cs == CS_DIV256) begin
      pre_mask = PRE_M256;
    end else begin
      pre_mask = PRE_M1024;
    end
  endfunction

  always_comb begin
    next_s          = s;
    next_s.osc_meta = timer_osc_input;
    next_s.osc_sync = s.osc_meta;
    next_s.osc_prev = s.osc_sync;
    base = async_clock_select ? (s.osc_sync & ~s.osc_prev) : 1'b1;
    if (base) begin
      next_s.pre = s.pre + 1'b1;
    end
    if (clock_select == CS_STOP) begin
      tick = 1'b0;
    end else if (clock_select == CS_DIV1) begin
      tick = base;
    end else begin
      tick = base && ((s.pre & pre_mask(clock_select)) ==
                      pre_mask(clock_select));
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
